// ===== bench/rsup_host_model.sv
// Host reset input model that counts the releases it sees on the reset line.
`timescale 1ns/10ps
module rsup_host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic reset_output_n,
  output logic      host_held,
  output int        releases
);
  logic last_r;
  // The host counts a release only on a rise that it samples on its own clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_r   <= 1'b0;
      releases <= 0;
    end else begin
      last_r <= reset_output_n;
      if (reset_output_n && !last_r) begin
        releases <= releases + 1;
      end
    end
  end
  assign host_held = !reset_output_n;
endmodule

// ===== bench/tb.sv
// Self-checking bench of the reset supervisor with its host model.
`timescale 1ns/10ps
`include "rsup_regs.svh"
module tb;
  import rsup_pkg::*;
  localparam int TK = 10;
  localparam int NR = 7;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [7:0]    awaddr = 8'h00;
  logic [7:0]    araddr = 8'h00;
  logic [31:0]   wdata = 32'h0;
  logic          awvalid = 1'b0;
  logic          wvalid = 1'b0;
  logic          bready = 1'b0;
  logic          arvalid = 1'b0;
  logic          rready = 1'b0;
  logic          pin = 1'b0;
  logic          sd = 1'b0;
  logic          pon = 1'b1;
  logic          uv = 1'b1;
  logic          thok = 1'b1;
  logic          pg4 = 1'b1;
  logic          en4 = 1'b1;
  logic [NR-1:0] rpg = '1;
  logic [NR-1:0] ren = '1;
  logic          awready;
  logic          wready;
  logic          bvalid;
  logic          arready;
  logic          rvalid;
  logic [1:0]    bresp;
  logic [1:0]    rresp;
  logic [31:0]   rdata;
  logic          rst_n;
  logic          deb;
  logic [11:0]   fsw;
  logic [1:0]    thsel;
  logic          held;
  int            rel;
  int            miscompares = 0;
  int            n_checks = 0;

  always #5 aclk = ~aclk;

  rsup_top #(.NUM_RAILS(NR), .TICK_CYCLES(TK)) u_rsup_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_on_pin(pin), .shutdown_seq(sd), .powered_on(pon),
    .primary_supply_uvlo_ok(uv), .primary_supply_above_thld(thok),
    .buck4_power_good(pg4), .buck4_enabled(en4), .rail_power_good(rpg),
    .rail_enabled(ren), .reset_output_n(rst_n), .power_on_debounced(deb),
    .switching_freq_khz(fsw), .supply_fail_threshold_select(thsel));

  rsup_host_model u_rsup_host_model (
    .aclk(aclk), .aresetn(aresetn), .reset_output_n(rst_n), .host_held(held),
    .releases(rel));

  function automatic int dly_t(input int c);
    return (c == 0) ? 200 : (c == 1) ? 100 : (c == 2) ? 20 : 2;
  endfunction
  function automatic int deb_t(input int c);
    return (c == 0) ? 1 : (c == 1) ? 20 : (c == 2) ? 80 : 320;
  endfunction
  function automatic logic [11:0] fsw_e(input int c);
    return 12'h44c + 12'(c) * 12'h226;
  endfunction

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tmo(input string nm);
    miscompares++;
    $display("unexpected %s: expected an answer, seen none", nm);
    summarize();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Waits for the reset line (or the debounced pin) to reach a level.
  task automatic wait_for(input bit s, input logic v, input int mx, output int n);
    n = 0;
    while ((s ? deb : rst_n) !== v) begin
      @(posedge aclk);
      n++;
      if (n > mx) tmo("level wait");
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    bit aw_t;
    bit w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (!aw_t && awready) begin
        aw_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_t && wready) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) tmo("write");
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    int i;
    bit a_t;
    a_t = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (!a_t && arready) begin
        a_t = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        chk("rdata", e, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) tmo("read");
  endtask

  initial begin
    int n;
    int c;
    logic [31:0] v;
    v = $urandom(32'hbfde);
    step(5);
    aresetn <= 1'b1;
    chk("reset_output_n", 32'h0, {31'h0, rst_n});
    wait_for(0, 1'b1, 1100, n);
    rng("default release delay", 1000, 1005, n);
    axr(`RSUP_CTRL_OFS, 32'hff, 32'h02, 2'h0);
    axr(`RSUP_RMON_OFS, 32'hff, 32'h18, 2'h0);
    axr(8'h0c, 32'hffffffff, 32'h0, 2'h2);
    axw(8'h0c, 32'hff, 2'h2);
    axw(`RSUP_STAT_OFS, 32'hff, 2'h0);
    chk("threshold", 32'h2, {30'h0, thsel});
    chk("freq", {20'h0, fsw_e(0)}, {20'h0, fsw});
    for (c = 3; c >= 0; c--) begin
      axw(`RSUP_CTRL_OFS, 32'h02 | (c << 4), 2'h0);
      step(2);
      chk("freq", {20'h0, fsw_e(c)}, {20'h0, fsw});
    end
    axr(`RSUP_STAT_OFS, 32'hff01, 32'({fsw_e(0) & 12'hff, 8'h01}), 2'h0);
    $display("test registers done");
    // Shutdown and undervoltage take turns as the cause of the drop.
    for (c = 0; c < 4; c++) begin
      axw(`RSUP_RMON_OFS, 32'h08 | (c << 4), 2'h0);
      @(posedge aclk);
      if (c[0]) uv <= 1'b0;
      else sd <= 1'b1;
      wait_for(0, 1'b0, 3, n);
      @(posedge aclk);
      uv <= 1'b1;
      sd <= 1'b0;
      wait_for(0, 1'b1, 2100, n);
      rng("release delay", dly_t(c) * TK, dly_t(c) * TK + 5, n);
    end
    $display("test delay codes done");
    axw(`RSUP_RMON_OFS, 32'h68, 2'h0);
    @(posedge aclk);
    pg4 <= 1'b0;
    wait_for(0, 1'b0, 3, n);
    rng("buck4 drop", 1, 2, n);
    @(posedge aclk);
    en4 <= 1'b0;
    wait_for(0, 1'b1, 300, n);
    rng("buck4 off release", 20 * TK, 20 * TK + 5, n);
    @(posedge aclk);
    en4 <= 1'b1;
    wait_for(0, 1'b0, 3, n);
    @(posedge aclk);
    pg4 <= 1'b1;
    step(100);
    pg4 <= 1'b0;
    step(5);
    pg4 <= 1'b1;
    wait_for(0, 1'b1, 300, n);
    rng("restarted delay", 20 * TK, 20 * TK + 5, n);
    $display("test buck4 mode done");
    c = $urandom % 4;
    axw(`RSUP_RMON_OFS, 32'h80 | (c << 2), 2'h0);
    chk("threshold", c, {30'h0, thsel});
    for (int i = 0; i < 12; i++) begin
      @(posedge aclk);
      pon  <= (i == 0) ? 1'b1 : 1'($urandom);
      thok <= (i == 0) ? 1'b0 : 1'($urandom);
      step(3);
      chk("supply mode", {31'h0, pon & thok}, {31'h0, rst_n});
    end
    @(posedge aclk);
    pon  <= 1'b1;
    thok <= 1'b1;
    $display("test supply mode done");
    axw(`RSUP_RMON_OFS, 32'hf8, 2'h0);
    @(posedge aclk);
    ren <= NR'($urandom) | NR'(1);
    wait_for(0, 1'b1, 40, n);
    @(posedge aclk);
    rpg <= ~NR'(1);
    wait_for(0, 1'b0, 3, n);
    rng("rail drop", 1, 2, n);
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      rpg <= NR'($urandom | $urandom);
      ren <= NR'($urandom);
      step(30);
      chk("all rails", {31'h0, &(rpg | ~ren)}, {31'h0, rst_n});
    end
    $display("test all rails done");
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      pin <= 1'($urandom);
      step(3);
      chk("level pin", {31'h0, pin}, {31'h0, deb});
    end
    // Each debounce code runs under another switching frequency, which must not matter.
    for (c = 0; c < 4; c++) begin
      axw(`RSUP_CTRL_OFS, 32'h01 | (c << 1) | ((3 - c) << 4), 2'h0);
      step(20);
      if (c == 1) begin
        pin <= ~pin;
        step(100);
        pin <= ~pin;
        step(250);
        chk("short glitch", {31'h0, pin}, {31'h0, deb});
      end
      pin <= ~pin;
      wait_for(1, ~deb, 3300, n);
      rng("debounce", (deb_t(c) - 1) * TK, deb_t(c) * TK + 5, n);
    end
    $display("test debounce done");
    chk("host releases", 32'h1, {31'h0, rel >= 8});
    chk("host held", {31'h0, ~rst_n}, {31'h0, held});
    summarize();
  end

  initial begin
    step(90000);
    tmo("run length");
  end
endmodule

// ===== logic/rsup_pkg.sv
// Types shared by the reset supervisor files.
package rsup_pkg;
  typedef enum logic [1:0] {
    RSUP_MON_NONE   = 2'h0,
    RSUP_MON_BUCK4  = 2'h1,
    RSUP_MON_SUPPLY = 2'h2,
    RSUP_MON_ALL    = 2'h3
  } rsup_mode_t;

  typedef enum logic [1:0] {
    RSUP_HOLD     = 2'h0,
    RSUP_COUNT    = 2'h1,
    RSUP_RELEASED = 2'h3
  } rsup_rel_state_t;
endpackage

// ===== logic/rsup_regs.svh
// Register offsets, field positions, reset values and timing figures of the reset supervisor.
`ifndef RSUP_REGS_SVH
`define RSUP_REGS_SVH

`define RSUP_CTRL_OFS      8'h00
`define RSUP_RMON_OFS      8'h04
`define RSUP_STAT_OFS      8'h08

`define RSUP_FREQ_LSB      4
`define RSUP_DEB_LSB       1
`define RSUP_TRIG_BIT      0
`define RSUP_MODE_LSB      6
`define RSUP_DLY_LSB       4
`define RSUP_THLD_LSB      2

`define RSUP_CTRL_RST      8'h02
`define RSUP_RMON_RST      8'h18

`define RSUP_CLK_NS        10
`define RSUP_TICK_US       500
`define RSUP_TICK_CYCLES   (`RSUP_TICK_US * 1000 / `RSUP_CLK_NS)

`define RSUP_DEB0_US       500
`define RSUP_DEB1_US       10000
`define RSUP_DEB2_US       40000
`define RSUP_DEB3_US       160000
`define RSUP_DLY0_US       100000
`define RSUP_DLY1_US       50000
`define RSUP_DLY2_US       10000
`define RSUP_DLY3_US       1000

`define RSUP_FSW0_KHZ      12'h44c
`define RSUP_FSW1_KHZ      12'h672
`define RSUP_FSW2_KHZ      12'h898
`define RSUP_FSW3_KHZ      12'habe

`endif

// ===== logic/rsup_tick_div.sv
// Restartable divider that gives a one-cycle tick every CYCLES clocks.
`timescale 1ns/10ps
module rsup_tick_div #(
  parameter int CYCLES = 50000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clear,
  output logic      tick
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_r;
  logic         tick_nxt;

  always_comb begin
    cnt_nxt  = cnt_r + W'(1);
    tick_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (cnt_r == LAST) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r & ~clear;
endmodule

// ===== logic/rsup_top.sv
// Reset-output supervisor with power-on debounce, frequency decode and AXI4-Lite registers.
// Notes on behaviour
// RULE1: The frequency code decodes to 1.1, 1.65, 2.2 and 2.75 MHz upward, default the lowest.
// RULE2: The debounce code selects 0.5, 10, 40 or 160 ms, default 10 ms.
// RULE3: Debounce applies to the power-on pin only in edge-trigger mode, else the pin passes.
// RULE4: Debounce time comes from a fixed timebase that ignores the switching frequency.
// RULE5: Mode 00 drops reset on shutdown or supply undervoltage and releases after the delay.
// RULE6: Mode 01 releases reset once buck 4 power-good has been good for the whole delay.
// RULE7: In mode 01 a buck 4 switched off by the bus counts as good.
// RULE8: In mode 01 reset drops at once when buck 4 power-good falls.
// RULE9: Mode 10 holds reset high above the undervoltage level and drops it at once below it.
// RULE10: Code 10 picks supply monitoring, whose rising level comes from a threshold field.
// RULE11: Mode 11 releases reset after the delay once every enabled rail is good.
// RULE12: In mode 11 reset drops at once when any monitored power-good falls.
// RULE13: The delay code selects 100, 50, 10 or 1 ms, default 50 ms, on the fixed timebase.
// RULE14: A release condition that drops before the delay ends restarts the delay.
`timescale 1ns/10ps
`include "rsup_regs.svh"
module rsup_top #(
  parameter int NUM_RAILS   = 7,
  parameter int TICK_CYCLES = `RSUP_TICK_CYCLES
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 power_on_pin,
  input  wire logic                 shutdown_seq,
  input  wire logic                 powered_on,
  input  wire logic                 primary_supply_uvlo_ok,
  input  wire logic                 primary_supply_above_thld,
  input  wire logic                 buck4_power_good,
  input  wire logic                 buck4_enabled,
  input  wire logic [NUM_RAILS-1:0] rail_power_good,
  input  wire logic [NUM_RAILS-1:0] rail_enabled,
  output logic                      reset_output_n,
  output logic                      power_on_debounced,
  output logic [11:0]               switching_freq_khz,
  output logic [1:0]                supply_fail_threshold_select
);
  import rsup_pkg::*;

  // Register fields.
  logic [7:0]      ctrl_r;
  logic [7:0]      ctrl_nxt;
  logic [7:0]      rmon_r;
  logic [7:0]      rmon_nxt;
  logic [1:0]      freq_sel;
  logic [1:0]      power_on_debounce_select;
  logic            power_on_trigger_select;
  rsup_mode_t      reset_monitor_select;
  logic [1:0]      reset_release_delay_select;

  // Bus state.
  logic            aw_held_r;
  logic            aw_held_nxt;
  logic [7:0]      awaddr_r;
  logic [7:0]      awaddr_nxt;
  logic            w_held_r;
  logic            w_held_nxt;
  logic [31:0]     wdata_r;
  logic [31:0]     wdata_nxt;
  logic            wstrb0_r;
  logic            wstrb0_nxt;
  logic            bvalid_r;
  logic            bvalid_nxt;
  logic [1:0]      bresp_r;
  logic [1:0]      bresp_nxt;
  logic            rvalid_r;
  logic            rvalid_nxt;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;
  logic [1:0]      rresp_r;
  logic [1:0]      rresp_nxt;

  // Supervisor state.
  logic [NUM_RAILS-1:0] rail_ok;
  logic            rel_cond;
  logic            rel_tick;
  logic [8:0]      rel_target;
  logic [8:0]      rel_cnt_r;
  logic [8:0]      rel_cnt_nxt;
  rsup_rel_state_t rel_state_r;
  rsup_rel_state_t rel_state_nxt;
  logic            rst_out_r;
  logic            rst_out_nxt;
  logic            deb_tick;
  logic [8:0]      deb_target;
  logic [8:0]      deb_cnt_r;
  logic [8:0]      deb_cnt_nxt;
  logic            deb_stable_r;
  logic            deb_stable_nxt;
  logic            pon_out_r;
  logic            pon_out_nxt;
  logic [11:0]     fsw_r;
  logic [11:0]     fsw_nxt;

  assign freq_sel                   = ctrl_r[`RSUP_FREQ_LSB +: 2];
  assign power_on_debounce_select   = ctrl_r[`RSUP_DEB_LSB +: 2];
  assign power_on_trigger_select    = ctrl_r[`RSUP_TRIG_BIT];
  assign reset_monitor_select       = rsup_mode_t'(rmon_r[`RSUP_MODE_LSB +: 2]);
  assign reset_release_delay_select = rmon_r[`RSUP_DLY_LSB +: 2];
  // The analog comparator picks its rising level from this field.
  assign supply_fail_threshold_select = rmon_r[`RSUP_THLD_LSB +: 2]; // [RULE10]

  // AXI4-Lite slave: address and data may come in either order, one write at a time.
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    ctrl_nxt    = ctrl_r;
    rmon_nxt    = rmon_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (aw_held_r && w_held_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = 2'h0;
      // All fields sit in byte lane 0, so other lanes are accepted and dropped.
      case (awaddr_r)
        `RSUP_CTRL_OFS: begin
          if (wstrb0_r) begin
            ctrl_nxt = wdata_r[7:0] & 8'h37;
          end
        end
        `RSUP_RMON_OFS: begin
          if (wstrb0_r) begin
            rmon_nxt = wdata_r[7:0] & 8'hfc;
          end
        end
        `RSUP_STAT_OFS: bresp_nxt = 2'h0;
        default:        bresp_nxt = 2'h2;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'h0;
      case (s_axi_araddr)
        `RSUP_CTRL_OFS: rdata_nxt = {24'h000000, ctrl_r};
        `RSUP_RMON_OFS: rdata_nxt = {24'h000000, rmon_r};
        `RSUP_STAT_OFS: rdata_nxt = {16'h0000, fsw_r[7:0], 3'h0, rel_state_r, pon_out_r,
                                     rel_cond, rst_out_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = 2'h2;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h00000000;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= 2'h0;
      ctrl_r    <= `RSUP_CTRL_RST;
      rmon_r    <= `RSUP_RMON_RST;
    end else begin
      aw_held_r <= aw_held_nxt;
      awaddr_r  <= awaddr_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      ctrl_r    <= ctrl_nxt;
      rmon_r    <= rmon_nxt;
    end
  end

  // A disabled rail cannot pull reset down.
  for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
    assign rail_ok[i] = rail_power_good[i] | ~rail_enabled[i];
  end

  always_comb begin
    case (reset_monitor_select)
      RSUP_MON_NONE:   rel_cond = ~shutdown_seq & primary_supply_uvlo_ok;          // [RULE5]
      RSUP_MON_BUCK4:  rel_cond = buck4_power_good | ~buck4_enabled;               // [RULE6] [RULE7]
      RSUP_MON_SUPPLY: rel_cond = powered_on & primary_supply_above_thld;          // [RULE9] [RULE10]
      RSUP_MON_ALL:    rel_cond = &rail_ok;                                        // [RULE11]
      default:         rel_cond = 1'b0;
    endcase
  end

  always_comb begin
    case (reset_release_delay_select)
      2'h0:    rel_target = 9'(`RSUP_DLY0_US / `RSUP_TICK_US); // [RULE13]
      2'h1:    rel_target = 9'(`RSUP_DLY1_US / `RSUP_TICK_US);
      2'h2:    rel_target = 9'(`RSUP_DLY2_US / `RSUP_TICK_US);
      default: rel_target = 9'(`RSUP_DLY3_US / `RSUP_TICK_US);
    endcase
  end

  // The divider is held in clear while the condition is bad, so the delay starts exactly
  // when the condition rises and is never shortened by a stale partial tick.
  rsup_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_rel_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (~rel_cond),
    .tick    (rel_tick)
  );

  always_comb begin
    rel_state_nxt = rel_state_r;
    rel_cnt_nxt   = rel_cnt_r;
    rst_out_nxt   = 1'b0;
    case (rel_state_r)
      RSUP_HOLD: begin
        rel_cnt_nxt = 9'h000;
        if (rel_cond) begin
          rel_state_nxt = RSUP_COUNT;
        end
      end
      RSUP_COUNT: begin
        if (rel_tick) begin
          rel_cnt_nxt = rel_cnt_r + 9'h001;
        end
        if (rel_cnt_r >= rel_target) begin
          rel_state_nxt = RSUP_RELEASED;
        end
      end
      RSUP_RELEASED: begin
        rst_out_nxt = 1'b1;
      end
      default: rel_state_nxt = RSUP_HOLD;
    endcase
    // Supply monitoring releases without any delay.
    if (reset_monitor_select == RSUP_MON_SUPPLY) begin
      rst_out_nxt = rel_cond; // [RULE9]
    end
    if (!rel_cond) begin
      rel_state_nxt = RSUP_HOLD;   // [RULE14]
      rel_cnt_nxt   = 9'h000;
      rst_out_nxt   = 1'b0;        // [RULE8] [RULE12]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rel_state_r <= RSUP_HOLD;
      rel_cnt_r   <= 9'h000;
      rst_out_r   <= 1'b0;
    end else begin
      rel_state_r <= rel_state_nxt;
      rel_cnt_r   <= rel_cnt_nxt;
      rst_out_r   <= rst_out_nxt;
    end
  end

  assign reset_output_n = rst_out_r;

  always_comb begin
    case (power_on_debounce_select)
      2'h0:    deb_target = 9'(`RSUP_DEB0_US / `RSUP_TICK_US); // [RULE2]
      2'h1:    deb_target = 9'(`RSUP_DEB1_US / `RSUP_TICK_US);
      2'h2:    deb_target = 9'(`RSUP_DEB2_US / `RSUP_TICK_US);
      default: deb_target = 9'(`RSUP_DEB3_US / `RSUP_TICK_US);
    endcase
  end

  // Fixed timebase, untouched by the switching-frequency field.
  rsup_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_deb_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (power_on_pin == deb_stable_r), // [RULE4]
    .tick    (deb_tick)
  );

  always_comb begin
    deb_stable_nxt = deb_stable_r;
    deb_cnt_nxt    = 9'h000;
    if (power_on_pin != deb_stable_r) begin
      deb_cnt_nxt = deb_cnt_r + {8'h00, deb_tick};
      if (deb_cnt_r >= deb_target) begin
        deb_stable_nxt = power_on_pin;
        deb_cnt_nxt    = 9'h000;
      end
    end
    // Level mode bypasses the debounce filter entirely.
    pon_out_nxt = power_on_trigger_select ? deb_stable_nxt : power_on_pin; // [RULE3]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deb_stable_r <= 1'b0;
      deb_cnt_r    <= 9'h000;
      pon_out_r    <= 1'b0;
    end else begin
      deb_stable_r <= deb_stable_nxt;
      deb_cnt_r    <= deb_cnt_nxt;
      pon_out_r    <= pon_out_nxt;
    end
  end

  assign power_on_debounced = pon_out_r;

  always_comb begin
    case (freq_sel)
      2'h0:    fsw_nxt = `RSUP_FSW0_KHZ; // [RULE1]
      2'h1:    fsw_nxt = `RSUP_FSW1_KHZ;
      2'h2:    fsw_nxt = `RSUP_FSW2_KHZ;
      default: fsw_nxt = `RSUP_FSW3_KHZ;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fsw_r <= `RSUP_FSW0_KHZ;
    end else begin
      fsw_r <= fsw_nxt;
    end
  end

  assign switching_freq_khz = fsw_r;

  freq_top_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    (freq_sel == 2'h3) |=> (switching_freq_khz == 12'habe))
    else $error("Top frequency code did not decode to 2.75 MHz.");

  deb_map_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    (power_on_debounce_select == 2'h1) |-> (deb_target == 9'h014))
    else $error("Debounce code 01 is not twenty ticks.");

  level_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    !power_on_trigger_select |=> (power_on_debounced == $past(power_on_pin)))
    else $error("Power-on pin was filtered in level mode.");

  shutdown_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
    (reset_monitor_select == RSUP_MON_NONE && shutdown_seq) |=> !reset_output_n)
    else $error("Reset stayed high during shutdown.");

  buck4_off_good_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
    (reset_monitor_select == RSUP_MON_BUCK4 && !buck4_enabled) |-> rel_cond)
    else $error("Disabled buck 4 was not treated as good.");

  buck4_fall_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
    (reset_monitor_select == RSUP_MON_BUCK4 && buck4_enabled && !buck4_power_good)
    |=> !reset_output_n)
    else $error("Reset did not drop when buck 4 power-good fell.");

  supply_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
    (reset_monitor_select == RSUP_MON_SUPPLY) ##1 (reset_monitor_select == RSUP_MON_SUPPLY)
    |-> (reset_output_n == ($past(powered_on) & $past(primary_supply_above_thld))))
    else $error("Supply mode did not follow the supply level.");

  rail_fall_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
    (reset_monitor_select == RSUP_MON_ALL && !(&rail_ok)) |=> !reset_output_n)
    else $error("Reset did not drop on a rail fault.");

  delay_map_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
    (reset_release_delay_select == 2'h1) |-> (rel_target == 9'h064))
    else $error("Delay code 01 is not one hundred ticks.");

  release_after_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
    ($rose(reset_output_n) && reset_monitor_select != RSUP_MON_SUPPLY)
    |-> ($past(rel_state_r) == RSUP_RELEASED && $past(rel_cnt_r) >= $past(rel_target)))
    else $error("Reset released before the delay ran out.");

  restart_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE14]
    !rel_cond |=> (rel_cnt_r == 9'h000 && rel_state_r == RSUP_HOLD))
    else $error("Release delay did not restart.");
endmodule
